// [shared/pls_regs.vh]
/*
 * constants of the process load and stall monitor: setting defaults,
 * stop reaction codes and timing counts.
 * assumes a 25 MHz core clock and settings in the units listed per macro.
 */
`ifndef PLS_REGS_VH
`define PLS_REGS_VH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PLS_CLK_NS        40
`define PLS_TICK_MS       100
`define PLS_TICK_CYC      ((`PLS_TICK_MS * 1000000) / `PLS_CLK_NS)
`define PLS_TICKS_PER_S   8'h0a
`define PLS_TICKS_PER_MIN 16'h0258

// ----------------------------------------------------------------------
// stop reaction codes
// ----------------------------------------------------------------------
`define PLS_REACT_IGNORE  2'h0
`define PLS_REACT_FREE    2'h1
`define PLS_REACT_RAMP    2'h2
`define PLS_REACT_FAST    2'h3

// ----------------------------------------------------------------------
// setting defaults (freq 0.1 Hz, torque/current 0.1 %, time as noted)
// ----------------------------------------------------------------------
`define PLS_UL_DLY_DEF    8'h00
`define PLS_UL_NOM_DEF    16'h0258
`define PLS_UL_ZERO_DEF   16'h0000
`define PLS_UL_FMIN_DEF   16'h0000
`define PLS_HYST_DEF      16'h0003
`define PLS_UL_REACT_DEF  `PLS_REACT_FREE
`define PLS_UL_RST_DEF    4'h0
`define PLS_OL_DLY_DEF    8'h00
`define PLS_OL_THR_DEF    16'h044c
`define PLS_OL_REACT_DEF  `PLS_REACT_FREE
`define PLS_OL_RST_DEF    4'h0
`define PLS_ST_EN_DEF     1'b0
`define PLS_ST_TIME_DEF   16'h0258
`define PLS_ST_CUR_DEF    16'h05dc
`define PLS_ST_FREQ_DEF   16'h0014
`define PLS_RATED_F_DEF   16'h01f4

// ----------------------------------------------------------------------
// hysteresis ratio 11/10 on the underload limit
// ----------------------------------------------------------------------
`define PLS_HYS_NUM       20'h0000b
`define PLS_HYS_DEN       20'h0000a

`endif

// [design/pls_timer.v]
/*
 * tick counter used for detection delays and restart inhibit times.
 * assumes tick_in is a one-cycle pulse on core_clk_in.
 */
`timescale 1ns/1ps

module pls_timer (
  input  wire        core_clk_in,
  input  wire        rstn_in,
  input  wire        tick_in,
  input  wire        run_in,
  input  wire        clr_in,
  input  wire [15:0] limit_in,
  output wire        expired_out
);

  reg  [15:0] cnt_r;
  reg  [15:0] cnt_nxt;

  always @* begin
    cnt_nxt = cnt_r;
    if (clr_in || !run_in) begin
      cnt_nxt = 16'h0000;
    end else if (tick_in && (cnt_r != 16'hffff)) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  always @(posedge core_clk_in) begin
    if (!rstn_in) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign expired_out = run_in && (cnt_r >= limit_in);

endmodule

// [design/pls_monitor.v]
/*
 * process underload, process overload and motor stall supervision with
 * configurable underload/overload stop reaction and restart inhibit; stall always freewheels.
 * assumes measurement inputs synchronous to core_clk_in; settings are
 * captured on cfg_load_in and take their defaults at reset.
 */
`timescale 1ns/1ps
`include "pls_regs.vh"

// What this block does
// - underload after steady low torque lasts the underload delay
// - steady state when reference and motor frequency differ less than hysteresis
// - underload limit follows zero threshold plus span times f squared over fn squared
// - no underload detection below the minimum underload frequency
// - underload timer clears when torque exceeds limit plus ten percent
// - zero delay disables the underload or overload monitor
// - nominal-speed underload threshold in percent torque, default sixty
// - zero-speed threshold defaults zero, never above nominal-speed threshold
// - underload reaction ignore, freewheel, ramp or fast; freewheel default
// - underload blocks auto restart for set minutes; reset time needs one more
// - overload blocks auto restart for its set minutes, default zero
// - overload when current limit or steady overcurrent lasts the overload delay
// - overload threshold percent of rated current, default 110, below limit
// - overload monitoring stays active during current limitation
// - overload reaction ignore, freewheel, ramp or fast; freewheel default
// - enabled stall error when low frequency and high current outlast stall time
// - stall time setting defaults to sixty seconds
// - stall current percent of rated current, default 150
// - stall frequency setting defaults to 2.0 Hz

module pls_monitor #(
  parameter TICK_CYC = `PLS_TICK_CYC
) (
  input  wire        core_clk_in,
  input  wire        rstn_in,
  input  wire [15:0] freq_ref_in,
  input  wire [15:0] motor_freq_in,
  input  wire [15:0] torque_in,
  input  wire [15:0] current_in,
  input  wire        curr_limit_in,
  input  wire        cfg_load_in,
  input  wire [15:0] cfg_rated_freq_in,
  input  wire [7:0]  cfg_ul_delay_in,
  input  wire [15:0] cfg_ul_nom_in,
  input  wire [15:0] cfg_ul_zero_in,
  input  wire [15:0] cfg_ul_fmin_in,
  input  wire [15:0] cfg_hyst_in,
  input  wire [1:0]  cfg_ul_react_in,
  input  wire [3:0]  cfg_ul_restart_in,
  input  wire [7:0]  cfg_ol_delay_in,
  input  wire [15:0] cfg_ol_thr_in,
  input  wire [1:0]  cfg_ol_react_in,
  input  wire [3:0]  cfg_ol_restart_in,
  input  wire        cfg_st_en_in,
  input  wire [15:0] cfg_st_time_in,
  input  wire [15:0] cfg_st_cur_in,
  input  wire [15:0] cfg_st_freq_in,
  input  wire [7:0]  fault_reset_min_in,
  input  wire        err_clear_in,
  output reg         ul_err_out,
  output reg         ol_err_out,
  output reg         stall_err_out,
  output reg         freewheel_out,
  output reg         ramp_stop_out,
  output reg         fast_stop_out,
  output reg         restart_block_out,
  output reg         auto_restart_ok_out,
  output reg         steady_out
);

  // --------------------------------------------------------------------
  // settings
  // --------------------------------------------------------------------
  reg  [15:0] rated_f_r;
  reg  [7:0]  ul_dly_r;
  reg  [15:0] ul_nom_r;
  reg  [15:0] ul_zero_r;
  reg  [15:0] ul_fmin_r;
  reg  [15:0] hyst_r;
  reg  [1:0]  ul_react_r;
  reg  [3:0]  ul_rst_r;
  reg  [7:0]  ol_dly_r;
  reg  [15:0] ol_thr_r;
  reg  [1:0]  ol_react_r;
  reg  [3:0]  ol_rst_r;
  reg         st_en_r;
  reg  [15:0] st_time_r;
  reg  [15:0] st_cur_r;
  reg  [15:0] st_freq_r;

  always @(posedge core_clk_in) begin
    if (!rstn_in) begin
      rated_f_r  <= `PLS_RATED_F_DEF;
      ul_dly_r   <= `PLS_UL_DLY_DEF;
      ul_nom_r   <= `PLS_UL_NOM_DEF;
      ul_zero_r  <= `PLS_UL_ZERO_DEF;
      ul_fmin_r  <= `PLS_UL_FMIN_DEF;
      hyst_r     <= `PLS_HYST_DEF;
      ul_react_r <= `PLS_UL_REACT_DEF;
      ul_rst_r   <= `PLS_UL_RST_DEF;
      ol_dly_r   <= `PLS_OL_DLY_DEF;
      ol_thr_r   <= `PLS_OL_THR_DEF;
      ol_react_r <= `PLS_OL_REACT_DEF;
      ol_rst_r   <= `PLS_OL_RST_DEF;
      st_en_r    <= `PLS_ST_EN_DEF;
      st_time_r  <= `PLS_ST_TIME_DEF;
      st_cur_r   <= `PLS_ST_CUR_DEF;
      st_freq_r  <= `PLS_ST_FREQ_DEF;
    end else if (cfg_load_in) begin
      rated_f_r  <= cfg_rated_freq_in;
      ul_dly_r   <= cfg_ul_delay_in;
      ul_nom_r   <= cfg_ul_nom_in;
      // zero-speed threshold clamped to the nominal one
      ul_zero_r  <= (cfg_ul_zero_in > cfg_ul_nom_in) ? cfg_ul_nom_in
                                                     : cfg_ul_zero_in;
      ul_fmin_r  <= cfg_ul_fmin_in;
      hyst_r     <= cfg_hyst_in;
      ul_react_r <= cfg_ul_react_in;
      ul_rst_r   <= cfg_ul_restart_in;
      ol_dly_r   <= cfg_ol_delay_in;
      ol_thr_r   <= cfg_ol_thr_in;
      ol_react_r <= cfg_ol_react_in;
      ol_rst_r   <= cfg_ol_restart_in;
      st_en_r    <= cfg_st_en_in;
      st_time_r  <= cfg_st_time_in;
      st_cur_r   <= cfg_st_cur_in;
      st_freq_r  <= cfg_st_freq_in;
    end
  end

  // --------------------------------------------------------------------
  // 100 ms tick
  // --------------------------------------------------------------------
  reg  [31:0] div_r;
  reg         tick_r;

  always @(posedge core_clk_in) begin
    if (!rstn_in) begin
      div_r  <= 32'h00000000;
      tick_r <= 1'b0;
    end else if (div_r >= TICK_CYC - 1) begin
      div_r  <= 32'h00000000;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // steady state and underload limit
  // --------------------------------------------------------------------
  wire [15:0] fdiff  = (freq_ref_in >= motor_freq_in) ? freq_ref_in - motor_freq_in
                                                      : motor_freq_in - freq_ref_in;
  wire        steady = fdiff < hyst_r;

  // above rated frequency the limit stays at the nominal threshold
  wire [15:0] fclip  = (motor_freq_in > rated_f_r) ? rated_f_r : motor_freq_in;
  wire [31:0] fc2    = fclip * fclip;
  wire [31:0] fn2    = rated_f_r * rated_f_r;
  wire [15:0] span   = ul_nom_r - ul_zero_r;

  // torque < zero + span*fc2/fn2, compared without division
  wire [15:0] t_ex   = torque_in - ul_zero_r;
  wire [47:0] lhs_lo = t_ex * fn2;
  wire [47:0] rhs_lo = span * fc2;
  wire        t_low  = (torque_in < ul_zero_r) || (lhs_lo < rhs_lo);

  // torque > 1.1 * limit, both sides scaled by ten
  wire [19:0] t10    = {4'h0, torque_in} * `PLS_HYS_DEN;
  wire [19:0] z11    = {4'h0, ul_zero_r} * `PLS_HYS_NUM;
  wire [19:0] s11    = {4'h0, span} * `PLS_HYS_NUM;
  wire [19:0] h_ex   = t10 - z11;
  wire [51:0] lhs_hi = h_ex * fn2;
  wire [51:0] rhs_hi = s11 * fc2;
  wire        t_high = (t10 > z11) && (lhs_hi > rhs_hi);

  wire        ul_on  = (ul_dly_r != 8'h00);
  wire        ol_on  = (ol_dly_r != 8'h00);
  wire        ul_run = ul_on && steady && (motor_freq_in >= ul_fmin_r)
                       && !t_high;
  wire        ul_cnt = ul_run && t_low;
  wire        ul_clr = !ul_run;

  // --------------------------------------------------------------------
  // overload and stall conditions
  // --------------------------------------------------------------------
  wire        ol_cond = ol_on && (curr_limit_in
                        || (steady && (current_in > ol_thr_r)));
  wire        st_cond = st_en_r && (motor_freq_in < st_freq_r)
                        && (current_in > st_cur_r);

  wire [15:0] ul_lim  = ul_dly_r * `PLS_TICKS_PER_S;
  wire [15:0] ol_lim  = ol_dly_r * `PLS_TICKS_PER_S;
  wire [15:0] st_lim  = (st_time_r == 16'hffff) ? st_time_r
                                                : st_time_r + 16'h0001;
  wire [15:0] ulr_lim = ul_rst_r * `PLS_TICKS_PER_MIN;
  wire [15:0] olr_lim = ol_rst_r * `PLS_TICKS_PER_MIN;

  // --------------------------------------------------------------------
  // timers
  // --------------------------------------------------------------------
  wire        ul_exp;
  wire        ol_exp;
  wire        st_exp;
  wire        ulr_exp;
  wire        olr_exp;
  reg         ul_exp_r;
  reg         ol_exp_r;
  reg         st_exp_r;
  reg         ulr_run_r;
  reg         olr_run_r;

  // counts only while torque is low; the band up to 1.1 * limit holds the count
  pls_timer u_ul_tmr (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .tick_in     (tick_r && ul_cnt),
    .run_in      (ul_run),
    .clr_in      (ul_clr),
    .limit_in    (ul_lim),
    .expired_out (ul_exp)
  );

  pls_timer u_ol_tmr (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .tick_in     (tick_r),
    .run_in      (ol_cond),
    .clr_in      (1'b0),
    .limit_in    (ol_lim),
    .expired_out (ol_exp)
  );

  pls_timer u_st_tmr (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .tick_in     (tick_r),
    .run_in      (st_cond),
    .clr_in      (1'b0),
    .limit_in    (st_lim),
    .expired_out (st_exp)
  );

  // detections are rising edges of the expired flags
  wire        ul_det = ul_exp && !ul_exp_r && (ul_react_r != `PLS_REACT_IGNORE);
  wire        ol_det = ol_exp && !ol_exp_r && (ol_react_r != `PLS_REACT_IGNORE);
  wire        st_det = st_exp && !st_exp_r;

  pls_timer u_ulr_tmr (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .tick_in     (tick_r),
    .run_in      (ulr_run_r),
    .clr_in      (ul_det),
    .limit_in    (ulr_lim),
    .expired_out (ulr_exp)
  );

  pls_timer u_olr_tmr (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .tick_in     (tick_r),
    .run_in      (olr_run_r),
    .clr_in      (ol_det),
    .limit_in    (olr_lim),
    .expired_out (olr_exp)
  );

  // --------------------------------------------------------------------
  // latches, stop pulses, restart inhibit
  // --------------------------------------------------------------------
  wire        free_nxt = (ul_det && (ul_react_r == `PLS_REACT_FREE))
                         || (ol_det && (ol_react_r == `PLS_REACT_FREE))
                         || st_det;
  wire        ramp_nxt = (ul_det && (ul_react_r == `PLS_REACT_RAMP))
                         || (ol_det && (ol_react_r == `PLS_REACT_RAMP));
  wire        fast_nxt = (ul_det && (ul_react_r == `PLS_REACT_FAST))
                         || (ol_det && (ol_react_r == `PLS_REACT_FAST));
  wire        ulr_nxt  = (ul_det && (ul_rst_r != 4'h0)) || (ulr_run_r && !ulr_exp);
  wire        olr_nxt  = (ol_det && (ol_rst_r != 4'h0)) || (olr_run_r && !olr_exp);
  wire [7:0]  ulr_need = {4'h0, ul_rst_r} + 8'h01;
  wire [7:0]  olr_need = {4'h0, ol_rst_r} + 8'h01;
  wire        ok_ul    = !ul_err_out || (fault_reset_min_in >= ulr_need);
  wire        ok_ol    = !ol_err_out || (fault_reset_min_in >= olr_need);

  always @(posedge core_clk_in) begin
    if (!rstn_in) begin
      ul_exp_r            <= 1'b0;
      ol_exp_r            <= 1'b0;
      st_exp_r            <= 1'b0;
      ulr_run_r           <= 1'b0;
      olr_run_r           <= 1'b0;
      ul_err_out          <= 1'b0;
      ol_err_out          <= 1'b0;
      stall_err_out       <= 1'b0;
      freewheel_out       <= 1'b0;
      ramp_stop_out       <= 1'b0;
      fast_stop_out       <= 1'b0;
      restart_block_out   <= 1'b0;
      auto_restart_ok_out <= 1'b0;
      steady_out          <= 1'b0;
    end else begin
      ul_exp_r            <= ul_exp;
      ol_exp_r            <= ol_exp;
      st_exp_r            <= st_exp;
      ulr_run_r           <= ulr_nxt;
      olr_run_r           <= olr_nxt;
      // set wins over clear
      ul_err_out          <= ul_det || (ul_err_out && !err_clear_in);
      ol_err_out          <= ol_det || (ol_err_out && !err_clear_in);
      stall_err_out       <= st_det || (stall_err_out && !err_clear_in);
      freewheel_out       <= free_nxt;
      ramp_stop_out       <= ramp_nxt;
      fast_stop_out       <= fast_nxt;
      restart_block_out   <= ulr_nxt || olr_nxt;
      auto_restart_ok_out <= ok_ul && ok_ol && !(ulr_nxt || olr_nxt);
      steady_out          <= steady;
    end
  end

endmodule

// [test/pls_monitor_sva.sv]
/* assertions on the load and stall monitor ports.
   assumes binding to pls_monitor with its tick length handed on. */
`timescale 1ns/1ps
`include "pls_regs.vh"
module pls_monitor_sva #(
  parameter TICK_CYC = 10
) (
  input wire        core_clk_in,
  input wire        rstn_in,
  input wire [15:0] freq_ref_in,
  input wire [15:0] motor_freq_in,
  input wire [15:0] current_in,
  input wire        cfg_load_in,
  input wire [7:0]  cfg_ul_delay_in,
  input wire [7:0]  cfg_ol_delay_in,
  input wire [15:0] cfg_hyst_in,
  input wire        cfg_st_en_in,
  input wire [15:0] cfg_st_time_in,
  input wire [15:0] cfg_st_cur_in,
  input wire [15:0] cfg_st_freq_in,
  input wire        err_clear_in,
  input wire        ul_err_out,
  input wire        ol_err_out,
  input wire        stall_err_out,
  input wire        freewheel_out,
  input wire        ramp_stop_out,
  input wire        fast_stop_out,
  input wire        steady_out
);
  // ----------------------------------------
  // settings copy and stall run length
  // ----------------------------------------
  reg  [7:0]  ul_dly_r, ol_dly_r;
  reg  [15:0] hyst_r, st_time_r, st_cur_r, st_freq_r;
  reg         st_en_r;
  reg  [31:0] st_cnt_r;
  wire [15:0] dif  = (freq_ref_in > motor_freq_in) ? freq_ref_in - motor_freq_in
                                                   : motor_freq_in - freq_ref_in;
  wire        stdy = dif < hyst_r;
  wire        stop = freewheel_out | ramp_stop_out | fast_stop_out;
  wire        st_c = (motor_freq_in < st_freq_r) & (current_in > st_cur_r);

  always @(posedge core_clk_in) begin
    if (!rstn_in) begin
      {ul_dly_r, ol_dly_r, st_en_r} <= {`PLS_UL_DLY_DEF, `PLS_OL_DLY_DEF, `PLS_ST_EN_DEF};
      {hyst_r, st_time_r, st_cur_r, st_freq_r} <= {`PLS_HYST_DEF, `PLS_ST_TIME_DEF,
                                                  `PLS_ST_CUR_DEF, `PLS_ST_FREQ_DEF};
    end else if (cfg_load_in) begin
      {ul_dly_r, ol_dly_r, st_en_r} <= {cfg_ul_delay_in, cfg_ol_delay_in, cfg_st_en_in};
      {hyst_r, st_time_r, st_cur_r, st_freq_r} <= {cfg_hyst_in, cfg_st_time_in,
                                                  cfg_st_cur_in, cfg_st_freq_in};
    end
    st_cnt_r <= (!rstn_in || !st_c) ? 32'h0 : st_cnt_r + 32'h1;
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_stall_hit;
    $rose(stall_err_out) ##0 st_en_r;
  endsequence
  sequence s_clear_quiet;
    err_clear_in ##1 !stop;
  endsequence

  a_steady_band: assert property (
    $past(rstn_in) && $past(rstn_in, 2) |-> steady_out == $past(stdy))
    else $error("steady flag does not match frequency band");
  a_stall_time: assert property (
    $rose(stall_err_out) |-> st_en_r && st_cnt_r >= st_time_r * TICK_CYC)
    else $error("stall error too early or while disabled");
  a_stall_stop: assert property (s_stall_hit |-> freewheel_out)
    else $error("stall error without freewheel pulse");
  a_ul_off: assert property (ul_dly_r == 8'h00 |-> !$rose(ul_err_out))
    else $error("underload detected with zero delay");
  a_ol_off: assert property (ol_dly_r == 8'h00 |-> !$rose(ol_err_out))
    else $error("overload detected with zero delay");
  a_stop_onehot: assert property (
    $onehot0({freewheel_out, ramp_stop_out, fast_stop_out}))
    else $error("more than one stop pulse");
  a_pulse_cause: assert property (
    stop |-> $rose(ul_err_out) || $rose(ol_err_out) || $rose(stall_err_out))
    else $error("stop pulse without new error");
  a_err_hold: assert property (
    $fell(ul_err_out) || $fell(ol_err_out) || $fell(stall_err_out) |-> $past(err_clear_in))
    else $error("error dropped without clear");
  a_clear_drop: assert property (
    s_clear_quiet |-> !(ul_err_out | ol_err_out | stall_err_out))
    else $error("error stayed after clear");
endmodule

bind pls_monitor pls_monitor_sva #(.TICK_CYC(TICK_CYC)) pls_monitor_sva_inst (
  .core_clk_in, .rstn_in, .freq_ref_in, .motor_freq_in, .current_in, .cfg_load_in,
  .cfg_ul_delay_in, .cfg_ol_delay_in, .cfg_hyst_in, .cfg_st_en_in, .cfg_st_time_in,
  .cfg_st_cur_in, .cfg_st_freq_in, .err_clear_in, .ul_err_out, .ol_err_out,
  .stall_err_out, .freewheel_out, .ramp_stop_out, .fast_stop_out, .steady_out
);

// [test/pls_drive_model.sv]
/* drive core model producing the measured values for the monitor.
   assumes wanted values from the bench, shown one edge later. */
`timescale 1ns/1ps
module pls_drive_model #(
  parameter ILIM = 16'h0708
) (
  input  wire        core_clk_in,
  input  wire [15:0] want_ref_in,
  input  wire [15:0] want_freq_in,
  input  wire [15:0] want_torque_in,
  input  wire [15:0] want_cur_in,
  output reg  [15:0] freq_ref_out,
  output reg  [15:0] motor_freq_out,
  output reg  [15:0] torque_out,
  output reg  [15:0] current_out,
  output reg         curr_limit_out
);
  // ----------------------------------------
  // limiter sits above every overload threshold used
  // ----------------------------------------
  initial {freq_ref_out, motor_freq_out, torque_out, current_out, curr_limit_out} = 65'h0;

  always @(posedge core_clk_in) begin
    freq_ref_out   <= #1 want_ref_in;
    motor_freq_out <= #1 want_freq_in;
    torque_out     <= #1 want_torque_in;
    current_out    <= #1 (want_cur_in > ILIM) ? ILIM : want_cur_in;
    curr_limit_out <= #1 want_cur_in >= ILIM;
  end
endmodule

// [test/test_pls_monitor.sv]
/* self-checking bench of the load and stall monitor.
   assumes pls_drive_model feeds the measured values. */
`timescale 1ns/1ps
`include "pls_regs.vh"
module test_pls_monitor;
  localparam int T = 10;
  logic        core_clk_in = 0, rstn_in = 0, cfg_load_in = 0, err_clear_in = 0;
  logic        cfg_st_en_in = 0, curr_limit_in;
  logic [15:0] freq_ref_in, motor_freq_in, torque_in, current_in;
  logic [15:0] cfg_rated_freq_in = 16'h01f4, cfg_ul_nom_in = 16'h0258;
  logic [15:0] cfg_ul_zero_in = 16'h00c8, cfg_ul_fmin_in = 16'h0064, cfg_hyst_in = 16'h0003;
  logic [15:0] cfg_ol_thr_in = 16'h044c, cfg_st_time_in = 16'h000a;
  logic [15:0] cfg_st_cur_in = 16'h05dc, cfg_st_freq_in = 16'h0014;
  logic [7:0]  cfg_ul_delay_in = 8'h01, cfg_ol_delay_in = 8'h00, fault_reset_min_in = 8'h01;
  logic [3:0]  cfg_ul_restart_in = 4'h0, cfg_ol_restart_in = 4'h0;
  logic [1:0]  cfg_ul_react_in = 2'h1, cfg_ol_react_in = 2'h2;
  logic        ul_err_out, ol_err_out, stall_err_out, freewheel_out, ramp_stop_out;
  logic        fast_stop_out, restart_block_out, auto_restart_ok_out, steady_out;
  logic [15:0] w_ref = 16'h0000, w_f = 16'h0000, w_tq = 16'h0000, w_cur = 16'h0000;
  logic [31:0] seed = 32'h62d5ec5a;
  int          bad_count = 0, num_checks = 0, n, a, b;

  pls_monitor #(.TICK_CYC(T)) pls_monitor_inst (
    .core_clk_in, .rstn_in, .freq_ref_in, .motor_freq_in, .torque_in, .current_in,
    .curr_limit_in, .cfg_load_in, .cfg_rated_freq_in, .cfg_ul_delay_in, .cfg_ul_nom_in,
    .cfg_ul_zero_in, .cfg_ul_fmin_in, .cfg_hyst_in, .cfg_ul_react_in, .cfg_ul_restart_in,
    .cfg_ol_delay_in, .cfg_ol_thr_in, .cfg_ol_react_in, .cfg_ol_restart_in, .cfg_st_en_in,
    .cfg_st_time_in, .cfg_st_cur_in, .cfg_st_freq_in, .fault_reset_min_in, .err_clear_in,
    .ul_err_out, .ol_err_out, .stall_err_out, .freewheel_out, .ramp_stop_out,
    .fast_stop_out, .restart_block_out, .auto_restart_ok_out, .steady_out
  );
  pls_drive_model pls_drive_model_inst (
    .core_clk_in, .want_ref_in(w_ref), .want_freq_in(w_f), .want_torque_in(w_tq),
    .want_cur_in(w_cur), .freq_ref_out(freq_ref_in), .motor_freq_out(motor_freq_in),
    .torque_out(torque_in), .current_out(current_in), .curr_limit_out(curr_limit_in)
  );

  initial begin
    forever #20 core_clk_in = ~core_clk_in;
  end

  // ----------------------------------------
  // model and helpers
  // ----------------------------------------
  function automatic int lim(input int f);
    return cfg_ul_zero_in + (cfg_ul_nom_in - cfg_ul_zero_in) * f * f
           / (cfg_rated_freq_in * cfg_rated_freq_in);
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic step(input int k);
    repeat (k) @(posedge core_clk_in);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] gt);
    num_checks++;
    if (gt !== ex) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, gt);
    end
  endtask
  task automatic meas(input int r, input int f, input int tq, input int c);
    {w_ref, w_f, w_tq, w_cur} = {16'(r), 16'(f), 16'(tq), 16'(c)};
  endtask
  task automatic pulse_in(input bit ld);
    if (ld) cfg_load_in = 1;
    else err_clear_in = 1;
    step(1);
    {cfg_load_in, err_clear_in} = 2'h0;
    step(2);
  endtask
  task automatic stop_test;
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_stop(input int mx, input bit must);
    n = 0;
    while (!(freewheel_out | ramp_stop_out | fast_stop_out) && n < mx) begin
      step(1);
      n++;
    end
    if (must && n >= mx) begin
      bad_count++;
      stop_test;
    end
  endtask
  task automatic ul_seg(input int mid);
    meas(250, 250, lim(250) - 50, 0);
    step(50);
    meas(250, 250, mid, 0);
    step(30);
    meas(250, 250, lim(250) - 50, 0);
    wait_stop(120, 1);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    step(10);
    rstn_in = 1;
    step(1);
    chk("reset_outputs", 16'h0000, {ul_err_out, ol_err_out, stall_err_out, restart_block_out});
    meas(10, 10, 0, 1700);
    wait_stop(300, 0);
    chk("defaults_off", 300, n[15:0]);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      {a, b} = {32'(seed[2:0]), 32'(seed[6:4])};
      meas(1000 + a, 1000 + b, 0, 0);
      step(2);
      chk("steady", (a - b < 3) && (b - a < 3), steady_out);
    end
    for (int r = 0; r < 4; r++) begin
      cfg_ul_react_in = r[1:0];
      pulse_in(1);
      meas(250, 250, lim(250) - 50, 0);
      wait_stop(150, r != 0);
      if (r == 0) chk("ul_ignore", 150, n[15:0]);
      else chk("ul_time", 1, n >= 88 && n <= 106);
      chk("ul_react", {r == 3, r == 2, r == 1, r != 0},
          {fast_stop_out, ramp_stop_out, freewheel_out, ul_err_out});
      meas(250, 250, 999, 0);
      step(1);
      chk("stop_pulse", 0, {fast_stop_out, ramp_stop_out, freewheel_out});
      pulse_in(0);
    end
    meas(50, 50, 0, 0);
    wait_stop(150, 0);
    chk("ul_below_fmin", 150, n[15:0]);
    ul_seg(lim(250) * 21 / 20);
    chk("ul_band_hold", 1, n >= 36 && n <= 58);
    meas(250, 250, 999, 0);
    pulse_in(0);
    ul_seg(lim(250) * 6 / 5);
    chk("ul_hyst_reset", 1, n >= 86);
    meas(250, 250, 999, 0);
    pulse_in(0);
    cfg_ul_restart_in = 4'h1;
    pulse_in(1);
    meas(250, 250, lim(250) - 50, 0);
    wait_stop(150, 1);
    chk("ul_block", 1, restart_block_out);
    n = 0;
    while (restart_block_out === 1'b1 && n < 7000) begin
      step(1);
      n++;
    end
    chk("ul_block_len", 1, n >= 5990 && n <= 6010);
    if (n >= 7000) stop_test;
    chk("restart_short", 0, auto_restart_ok_out);
    fault_reset_min_in = 8'h02;
    step(2);
    chk("restart_ok", 1, auto_restart_ok_out);
    meas(500, 500, 800, 0);
    pulse_in(0);
    {cfg_ul_delay_in, cfg_ol_delay_in} = {8'h00, 8'h01};
    pulse_in(1);
    meas(500, 500, 800, 1200);
    wait_stop(150, 1);
    chk("ol_time", 1, n >= 88 && n <= 106);
    chk("ol_ramp", 16'h0018, {ol_err_out, ramp_stop_out, freewheel_out,
                              fast_stop_out, restart_block_out});
    meas(500, 500, 800, 0);
    pulse_in(0);
    cfg_ol_react_in = 2'h3;
    pulse_in(1);
    meas(500, 300, 800, 1900);
    wait_stop(150, 1);
    chk("ol_limit", 16'h0006, {ol_err_out, fast_stop_out, steady_out});
    meas(500, 500, 800, 0);
    pulse_in(0);
    {cfg_ol_delay_in, cfg_st_en_in} = {8'h00, 1'b1};
    pulse_in(1);
    meas(20, 20, 0, 1600);
    wait_stop(130, 0);
    chk("stall_at_freq", 130, n[15:0]);
    meas(10, 10, 0, 1600);
    wait_stop(130, 1);
    chk("stall_time", 1, n >= 98 && n <= 118);
    chk("stall_err", 16'h0006, {stall_err_out, freewheel_out, ul_err_out});
    stop_test;
  end
endmodule
